// ===== design/cscf_pkg.sv
// constants and types of the charger control block
package cscf_pkg;

  // ****************************************
  // apb register map (byte address is four times index)
  // ****************************************
  localparam int unsigned APB_AW = 8;
  localparam logic [2:0] REG_CTRL0_IDX = 3'h0;
  localparam logic [2:0] REG_CTRL1_IDX = 3'h1;
  localparam logic [2:0] REG_VOLT_IDX = 3'h2;
  localparam logic [2:0] REG_LIVE_IDX = 3'h3;
  localparam logic [2:0] REG_CURR_IDX = 3'h4;
  localparam logic [2:0] REG_SPEC_IDX = 3'h5;
  localparam logic [2:0] REG_SAFE_IDX = 3'h6;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned F_WD_RESTART = 7;   // ctrl0
  localparam int unsigned F_STAT_LO = 4;      // ctrl0 [5:4]
  localparam int unsigned F_FAULT_LO = 0;     // ctrl0 [2:0]
  localparam int unsigned F_ILIM_LO = 6;      // ctrl1 [7:6]
  localparam int unsigned F_TERM_EN = 3;      // ctrl1
  localparam int unsigned F_CHG_DIS = 2;      // ctrl1
  localparam int unsigned F_HIZ_REQ = 1;      // ctrl1
  localparam int unsigned F_BOOST_REQ = 0;    // ctrl1
  localparam int unsigned F_VREG_LO = 2;      // volt [7:2]
  localparam int unsigned F_PIN_ALLOW = 1;    // volt
  localparam int unsigned F_PIN_POL = 0;      // volt
  localparam int unsigned F_CEIL_LO = 4;      // curr [6:4]
  localparam int unsigned F_ICHG_LO = 0;      // curr [2:0]
  localparam int unsigned F_VSP_SEL = 4;      // spec
  localparam int unsigned F_WD_EN = 7;        // safe

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [1:0] ILIM_RST = 2'h0;
  localparam logic TERM_EN_RST = 1'b1;
  localparam logic [5:0] VREG_RST = 6'h00;
  localparam logic [2:0] CEIL_RST = 3'h0;
  localparam logic [2:0] ICHG_RST = 3'h0;
  localparam logic [1:0] ILIM_500MA = 2'h1;   // input limit code in boost

  // ****************************************
  // status and fault codes
  // ****************************************
  localparam logic [1:0] STAT_READY = 2'h0;
  localparam logic [1:0] STAT_CHARGING = 2'h1;
  localparam logic [1:0] STAT_DONE = 2'h2;
  localparam logic [1:0] STAT_FAULT = 2'h3;
  localparam logic [2:0] FLT_NONE = 3'h0;
  localparam logic [2:0] FLT_VBUS_OVP = 3'h1;
  localparam logic [2:0] FLT_UVLO = 3'h3;
  localparam logic [2:0] FLT_BAT_OVP = 3'h4;
  localparam logic [2:0] FLT_TIMER = 3'h6;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ = 20_000_000;     // 50 ns period
  localparam int unsigned TICK_S = 1;              // prescaler tick, s
  localparam int unsigned SAFETY_MIN = 40;         // safety timer, min
  localparam int unsigned WATCHDOG_S = 32;         // host watchdog, s
  localparam int unsigned TICK_CYCLES_DEF = CLK_HZ * TICK_S;
  localparam int unsigned SAFETY_TICKS = SAFETY_MIN * 60 / TICK_S;
  localparam int unsigned WATCHDOG_TICKS = WATCHDOG_S / TICK_S;
  localparam int unsigned PRESC_W = 25;
  localparam int unsigned SAFE_W = 12;
  localparam int unsigned WD_W = 6;

  // ****************************************
  // synchronised input bit positions
  // ****************************************
  localparam int unsigned IN_POR = 0;
  localparam int unsigned IN_UVLO = 1;
  localparam int unsigned IN_VOVP = 2;
  localparam int unsigned IN_BOVP = 3;
  localparam int unsigned IN_SHORT = 4;
  localparam int unsigned IN_RECH = 5;
  localparam int unsigned IN_TERM = 6;
  localparam int unsigned IN_SLEEP = 7;
  localparam int unsigned IN_TJ_OVER = 8;
  localparam int unsigned IN_TJ_COOL = 9;
  localparam int unsigned IN_HS_OC = 10;
  localparam int unsigned IN_CYC = 11;
  localparam int unsigned IN_VSP = 12;
  localparam int unsigned IN_OTG = 13;
  localparam int unsigned NIN = 14;

  typedef enum logic [1:0] {
    MODE_HIZ,
    MODE_CHARGE,
    MODE_BOOST
  } cscf_mode_t;

endpackage

// ===== design/cscf_top.sv
// charger mode, timer and fault logic with apb registers
//
// Overview of operation
// [R1] - charge start starts safety timer
// [R2] - safety expiry: disable set, fault 110
// [R3] - restart by por or disable cleared
// [R4] - por clears fault; locked until read
// [R5] - watchdog off at reset, bit enables
// [R6] - any host write restarts watchdog; writes to unmapped addresses do not
// [R7] - restart bit restarts watchdog, self-clears
// [R8] - watchdog expiry restores defaults, recharges
// [R9] - fast current clamped to ceiling
// [R10] - 500mA limit in boost, else programmed
// [R11] - thermal shutdown stops switching, freezes timers
// [R12] - undervoltage stops charge, fault 011
// [R13] - input overvoltage stops converter, fault 001
// [R14] - battery overvoltage stops converter, fault 100
// [R15] - termination current ends charge if enabled
// [R16] - recharge level starts new cycle
// [R17] - boost from request bit or pin
// [R18] - one of charge, boost, high-impedance
// [R19] - short current below short threshold
// [R20] - sleep turns off switch and controller
// [R21] - peak overcurrent blocks high side
// [R22] - special voltage lowers frequency, limits current
// [R23] - timers from prescaled reference clock
//
// The register offsets and the APB slave port are this design's own decisions.
module cscf_top #(
  parameter int unsigned TICK_CYCLES = cscf_pkg::TICK_CYCLES_DEF
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [cscf_pkg::APB_AW-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic VBUS_POR_I,
  input wire logic VBUS_UVLO_I,
  input wire logic VBUS_OVP_I,
  input wire logic BAT_OVP_I,
  input wire logic BAT_SHORT_I,
  input wire logic BAT_RECHARGE_I,
  input wire logic TERM_CURRENT_I,
  input wire logic SLEEP_I,
  input wire logic TJ_OVER_I,
  input wire logic TJ_COOL_I,
  input wire logic HS_OVERCURRENT_I,
  input wire logic PWM_CYCLE_I,
  input wire logic VSP_REACHED_I,
  input wire logic OTG_PIN_I,
  output logic CHARGE_MODE_O,
  output logic BOOST_MODE_O,
  output logic CHARGE_EN_O,
  output logic CONVERTER_EN_O,
  output logic HS_GATE_EN_O,
  output logic REV_SWITCH_EN_O,
  output logic SHORT_CURRENT_O,
  output logic FREQ_REDUCE_O,
  output logic VSP_SEL_O,
  output logic [1:0] INPUT_LIMIT_O,
  output logic [2:0] CHARGE_CURRENT_O,
  output logic [5:0] VREG_O
);
  import cscf_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [NIN-1:0] s1;
    logic [NIN-1:0] s2;
    logic por_d;
    logic cyc_d;
    logic [31:0] prdata;
    logic wd_restart;
    logic [1:0] ilim;
    logic term_en;
    logic chg_dis;
    logic hiz_req;
    logic boost_req;
    logic [5:0] vreg;
    logic pin_allow;
    logic pin_pol;
    logic [2:0] ceil;
    logic [2:0] ichg;
    logic vsp_sel;
    logic wd_en;
    logic [2:0] fault;
    logic lock;
    logic [1:0] stat;
    cscf_mode_t mode;
    logic charging;
    logic done;
    logic tshut;
    logic hs_block;
    logic [PRESC_W-1:0] presc;
    logic [SAFE_W-1:0] safe_cnt;
    logic [WD_W-1:0] wd_cnt;
  } cscf_state_t;

  cscf_state_t s_reg;
  cscf_state_t s_next;

  logic [NIN-1:0] in_vec;
  logic [2:0] idx;
  logic addr_ok;
  logic setup;
  logic wr_evt;
  logic rd0_evt;
  logic por_evt;
  logic tick;
  logic boost_on;
  logic uvlo;
  logic vovp;
  logic bovp;
  logic sleep;
  logic charge_ok;
  logic chg_now;
  logic chg_begin;
  logic safe_exp;
  logic wd_exp;
  logic [2:0] new_code;
  logic [2:0] wr_ichg;
  logic [31:0] rd_word;

  // comparator and pin levels, synchronised below
  assign in_vec = {OTG_PIN_I, VSP_REACHED_I, PWM_CYCLE_I, HS_OVERCURRENT_I,
                   TJ_COOL_I, TJ_OVER_I, SLEEP_I, TERM_CURRENT_I,
                   BAT_RECHARGE_I, BAT_SHORT_I, BAT_OVP_I, VBUS_OVP_I,
                   VBUS_UVLO_I, VBUS_POR_I};

  // ****************************************
  // apb: zero wait states, error when unmapped
  // ****************************************
  assign idx = PADDR_I[4:2];
  assign addr_ok = (PADDR_I[APB_AW-1:5] == '0) && (PADDR_I[1:0] == 2'b00)
                   && (idx <= REG_SAFE_IDX);
  assign PREADY_O = PSEL_I & PENABLE_I;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_ok;
  assign PRDATA_O = s_reg.prdata;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    setup = PSEL_I & ~PENABLE_I;
    wr_evt = PSEL_I & PENABLE_I & PWRITE_I & addr_ok;
    rd0_evt = PSEL_I & PENABLE_I & ~PWRITE_I & addr_ok
              & (idx == REG_CTRL0_IDX);
    tick = 1'b0;
    safe_exp = 1'b0;
    wd_exp = 1'b0;
    new_code = FLT_NONE;
    wr_ichg = '0;
    rd_word = '0;

    // two-flop synchronisers; logic reads stage two
    s_next.s1 = in_vec;
    s_next.s2 = s_reg.s1;
    s_next.por_d = s_reg.s2[IN_POR];
    s_next.cyc_d = s_reg.s2[IN_CYC];

    por_evt = s_reg.s2[IN_POR] & ~s_reg.por_d;
    uvlo = s_reg.s2[IN_UVLO];
    vovp = s_reg.s2[IN_VOVP];
    bovp = s_reg.s2[IN_BOVP];
    sleep = s_reg.s2[IN_SLEEP];

    // thermal latch, released at the cool level
    if (s_reg.s2[IN_TJ_OVER]) begin
      s_next.tshut = 1'b1;
    end else if (s_reg.s2[IN_TJ_COOL]) begin
      s_next.tshut = 1'b0;
    end

    // tick prescaler; frozen when hot so timers hold
    if (!s_reg.tshut) begin // [R11] [R23]
      if (s_reg.presc == PRESC_W'(TICK_CYCLES - 1)) begin
        s_next.presc = '0;
        tick = 1'b1;
      end else begin
        s_next.presc = s_reg.presc + PRESC_W'(1);
      end
    end

    // boost from request bit or qualified pin
    boost_on = s_reg.boost_req
               | (s_reg.pin_allow & (s_reg.s2[IN_OTG] == s_reg.pin_pol)); // [R17]

    // single operating mode; high-impedance otherwise
    if (boost_on && !s_reg.tshut) begin // [R18]
      s_next.mode = MODE_BOOST;
    end else if (!s_reg.hiz_req && !sleep) begin
      s_next.mode = MODE_CHARGE;
    end else begin
      s_next.mode = MODE_HIZ;
    end

    // charge only with no protection active
    charge_ok = ~s_reg.chg_dis & ~uvlo & ~vovp & ~bovp & ~sleep
                & ~s_reg.tshut; // [R11] [R12] [R13] [R14] [R20]
    chg_now = (s_reg.mode == MODE_CHARGE) & charge_ok & ~s_reg.done;
    s_next.charging = chg_now;
    chg_begin = chg_now & ~s_reg.charging;

    // termination and recharge
    if (s_reg.charging && s_reg.term_en && s_reg.s2[IN_TERM]) begin
      s_next.done = 1'b1; // [R15]
    end else if (s_reg.done && s_reg.s2[IN_RECH]) begin
      s_next.done = 1'b0; // [R16]
    end

    // peak current blocks high side to a clean cycle
    if (s_reg.s2[IN_HS_OC]) begin
      s_next.hs_block = 1'b1; // [R21]
    end else if (s_reg.s2[IN_CYC] && !s_reg.cyc_d) begin
      s_next.hs_block = 1'b0; // [R21]
    end

    // host writes; hardware events below win
    s_next.wd_restart = 1'b0;
    if (wr_evt) begin
      case (idx)
        REG_CTRL0_IDX: begin
          s_next.wd_restart = PWDATA_I[F_WD_RESTART]; // [R7]
        end
        REG_CTRL1_IDX: begin
          s_next.ilim = PWDATA_I[F_ILIM_LO +: 2];
          s_next.term_en = PWDATA_I[F_TERM_EN];
          s_next.chg_dis = PWDATA_I[F_CHG_DIS]; // [R3]
          s_next.hiz_req = PWDATA_I[F_HIZ_REQ];
          s_next.boost_req = PWDATA_I[F_BOOST_REQ];
        end
        REG_VOLT_IDX: begin
          s_next.vreg = PWDATA_I[F_VREG_LO +: 6];
          s_next.pin_allow = PWDATA_I[F_PIN_ALLOW];
          s_next.pin_pol = PWDATA_I[F_PIN_POL];
        end
        REG_CURR_IDX: begin
          // clamp to the ceiling in the same word
          wr_ichg = PWDATA_I[F_ICHG_LO +: 3];
          s_next.ceil = PWDATA_I[F_CEIL_LO +: 3];
          if (wr_ichg > PWDATA_I[F_CEIL_LO +: 3]) begin
            s_next.ichg = PWDATA_I[F_CEIL_LO +: 3]; // [R9]
          end else begin
            s_next.ichg = wr_ichg;
          end
        end
        REG_SPEC_IDX: begin
          s_next.vsp_sel = PWDATA_I[F_VSP_SEL];
        end
        REG_SAFE_IDX: begin
          s_next.wd_en = PWDATA_I[F_WD_EN]; // [R5]
        end
        default: begin
        end
      endcase
    end

    // a boost fault drops the request, back to charge
    if (s_reg.mode == MODE_BOOST && (vovp || bovp)) begin
      s_next.boost_req = 1'b0;
    end

    // watchdog: cleared by any mapped write or restart bit
    if (!s_reg.wd_en || wr_evt || s_reg.wd_restart) begin
      s_next.wd_cnt = '0; // [R5] [R6] [R7]
    end else if (tick) begin
      if (s_reg.wd_cnt == WD_W'(WATCHDOG_TICKS - 1)) begin
        wd_exp = 1'b1;
        s_next.wd_cnt = '0;
      end else begin
        s_next.wd_cnt = s_reg.wd_cnt + WD_W'(1);
      end
    end

    // watchdog expiry restores defaults, resumes charge
    if (wd_exp) begin // [R8]
      s_next.ilim = ILIM_RST;
      s_next.term_en = TERM_EN_RST;
      s_next.chg_dis = 1'b0;
      s_next.vreg = VREG_RST;
      s_next.ichg = ICHG_RST;
      s_next.vsp_sel = 1'b0;
      s_next.done = 1'b0;
    end

    // safety timer restarts at charge start or expiry
    if (por_evt || chg_begin || wd_exp) begin
      s_next.safe_cnt = '0; // [R1] [R8]
    end else if (s_reg.charging && tick) begin
      if (s_reg.safe_cnt == SAFE_W'(SAFETY_TICKS - 1)) begin
        safe_exp = 1'b1;
        s_next.safe_cnt = '0;
      end else begin
        s_next.safe_cnt = s_reg.safe_cnt + SAFE_W'(1); // [R1]
      end
    end

    // expiry disables charge; wins over a host clear
    if (safe_exp) begin
      s_next.chg_dis = 1'b1; // [R2]
    end
    // a power-on rising edge also re-enables charge
    if (por_evt) begin
      s_next.chg_dis = 1'b0; // [R3]
    end

    // fault code, highest priority first
    if (safe_exp) begin
      new_code = FLT_TIMER; // [R2]
    end else if (bovp) begin
      new_code = FLT_BAT_OVP; // [R14]
    end else if (vovp) begin
      new_code = FLT_VBUS_OVP; // [R13]
    end else if (uvlo && s_reg.mode == MODE_CHARGE) begin
      new_code = FLT_UVLO; // [R12]
    end

    // fault field holds until the host reads the status word
    if (rd0_evt) begin
      s_next.lock = 1'b0;
    end
    if (por_evt) begin
      s_next.fault = FLT_NONE; // [R4]
      s_next.lock = 1'b0;
    end else if (new_code != FLT_NONE && !s_reg.lock) begin
      s_next.fault = new_code; // [R4]
      s_next.lock = 1'b1;
    end else if (!s_reg.lock && s_reg.fault != FLT_TIMER
                 && new_code == FLT_NONE) begin
      s_next.fault = FLT_NONE; // [R13] [R14]
    end

    // state code
    if (uvlo || vovp || bovp) begin
      s_next.stat = STAT_FAULT; // [R12] [R13] [R14]
    end else if (s_reg.charging) begin
      s_next.stat = STAT_CHARGING;
    end else if (s_reg.done) begin
      s_next.stat = STAT_DONE;
    end else begin
      s_next.stat = STAT_READY;
    end

    // read word, captured in the setup cycle
    case (idx)
      REG_CTRL0_IDX: begin
        rd_word[F_STAT_LO +: 2] = s_reg.stat;
        rd_word[F_FAULT_LO +: 3] = s_reg.fault;
      end
      REG_CTRL1_IDX: begin
        rd_word[F_ILIM_LO +: 2] = s_reg.ilim;
        rd_word[F_TERM_EN] = s_reg.term_en;
        rd_word[F_CHG_DIS] = s_reg.chg_dis;
        rd_word[F_HIZ_REQ] = s_reg.hiz_req;
        rd_word[F_BOOST_REQ] = s_reg.boost_req;
      end
      REG_VOLT_IDX: begin
        rd_word[F_VREG_LO +: 6] = s_reg.vreg;
        rd_word[F_PIN_ALLOW] = s_reg.pin_allow;
        rd_word[F_PIN_POL] = s_reg.pin_pol;
      end
      REG_LIVE_IDX: begin
        rd_word[7:0] = {s_reg.tshut, sleep, bovp, vovp, uvlo,
                        s_reg.s2[IN_SHORT], s_reg.hs_block, s_reg.done};
      end
      REG_CURR_IDX: begin
        rd_word[F_CEIL_LO +: 3] = s_reg.ceil;
        rd_word[F_ICHG_LO +: 3] = s_reg.ichg;
      end
      REG_SPEC_IDX: begin
        rd_word[F_VSP_SEL] = s_reg.vsp_sel;
      end
      REG_SAFE_IDX: begin
        rd_word[F_WD_EN] = s_reg.wd_en;
      end
      default: begin
      end
    endcase
    if (setup) begin
      s_next.prdata = addr_ok ? rd_word : 32'h0000_0000;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_reg <= '0;
      s_reg.term_en <= TERM_EN_RST;
      s_reg.ilim <= ILIM_RST;
      s_reg.vreg <= VREG_RST;
      s_reg.ceil <= CEIL_RST;
      s_reg.ichg <= ICHG_RST;
      s_reg.wd_en <= 1'b0; // [R5]
      s_reg.mode <= MODE_HIZ;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // outputs to the power stage
  // ****************************************
  // converter idle in high-impedance, in sleep while charging, and when hot
  assign CHARGE_MODE_O = (s_reg.mode == MODE_CHARGE); // [R18]
  assign BOOST_MODE_O = (s_reg.mode == MODE_BOOST); // [R18]
  assign CHARGE_EN_O = s_reg.charging;
  assign CONVERTER_EN_O = (s_reg.charging | BOOST_MODE_O) & ~s_reg.tshut
                          & ~(s_reg.charging & sleep); // [R11] [R20]
  assign HS_GATE_EN_O = CONVERTER_EN_O & ~s_reg.hs_block; // [R21]
  assign REV_SWITCH_EN_O = ~sleep & (s_reg.mode != MODE_HIZ); // [R20]
  assign SHORT_CURRENT_O = s_reg.charging & s_reg.s2[IN_SHORT]; // [R19]
  assign FREQ_REDUCE_O = s_reg.charging & s_reg.s2[IN_VSP]; // [R22]
  assign VSP_SEL_O = s_reg.vsp_sel; // [R22]
  assign INPUT_LIMIT_O = BOOST_MODE_O ? ILIM_500MA : s_reg.ilim; // [R10]
  // fast step held while input sits at special voltage
  assign CHARGE_CURRENT_O = s_reg.s2[IN_VSP] ? 3'h0 : s_reg.ichg; // [R22]
  assign VREG_O = s_reg.vreg;

endmodule

// ===== test/cscf_checker.sv
// port assertions for the charger control block
module cscf_checker (
  input logic REF_CLK_I,
  input logic RST_I,
  input logic PSEL_I,
  input logic PENABLE_I,
  input logic PWRITE_I,
  input logic [cscf_pkg::APB_AW-1:0] PADDR_I,
  input logic [31:0] PRDATA_O,
  input logic VBUS_UVLO_I,
  input logic VBUS_OVP_I,
  input logic BAT_OVP_I,
  input logic BAT_SHORT_I,
  input logic SLEEP_I,
  input logic TJ_OVER_I,
  input logic HS_OVERCURRENT_I,
  input logic VSP_REACHED_I,
  input logic CHARGE_MODE_O,
  input logic BOOST_MODE_O,
  input logic CHARGE_EN_O,
  input logic CONVERTER_EN_O,
  input logic HS_GATE_EN_O,
  input logic REV_SWITCH_EN_O,
  input logic SHORT_CURRENT_O,
  input logic [1:0] INPUT_LIMIT_O,
  input logic [2:0] CHARGE_CURRENT_O
);
  import cscf_pkg::*;
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);
  // ****************************************************************
  // assertions; [*4] spans the input synchroniser
  // ****************************************************************
  chk_one_mode: assert property (!(CHARGE_MODE_O && BOOST_MODE_O))
    else $error("both modes on");
  chk_hiz_idle: assert property (
    (!CHARGE_MODE_O && !BOOST_MODE_O)[*2] |-> !CHARGE_EN_O)
    else $error("charging in hiz");
  chk_boost_limit: assert property (
    BOOST_MODE_O |-> INPUT_LIMIT_O == ILIM_500MA)
    else $error("boost limit wrong");
  chk_fault_stop: assert property (
    (VBUS_OVP_I || VBUS_UVLO_I || BAT_OVP_I)[*4] |-> !CHARGE_EN_O)
    else $error("charging in fault");
  chk_thermal_off: assert property (
    TJ_OVER_I[*4] |-> !CONVERTER_EN_O)
    else $error("converter on hot");
  chk_sleep_off: assert property (
    (SLEEP_I && !BOOST_MODE_O)[*4] |-> !REV_SWITCH_EN_O && !CONVERTER_EN_O)
    else $error("on in sleep");
  chk_hs_block: assert property (
    HS_OVERCURRENT_I[*4] |-> !HS_GATE_EN_O)
    else $error("hs on at peak");
  chk_short_off: assert property (
    (!BAT_SHORT_I)[*4] |-> !SHORT_CURRENT_O)
    else $error("short current on");
  chk_vsp_curr: assert property (
    VSP_REACHED_I[*4] |-> CHARGE_CURRENT_O == 3'h0)
    else $error("current not held");
  chk_restart_zero: assert property (
    (PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == '0) |=> !PRDATA_O[7])
    else $error("restart bit reads one");
  cov_boost: cover property (BOOST_MODE_O);
  cov_stopped: cover property (CHARGE_MODE_O && !CHARGE_EN_O);
  cov_write: cover property (PSEL_I && PENABLE_I && PWRITE_I);
endmodule
bind cscf_top cscf_checker u_chk (.*);

// ===== test/cscf_host.sv
// host model: apb master for the charger registers
module cscf_host (
  input logic clk_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o,
  input logic [31:0] prdata_i,
  input logic pready_i,
  input logic pslverr_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // bus idle from time zero, through reset
  initial begin
    {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
  end
  // one transfer from a rising edge; held until ready
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    while (!pready_i) begin
      @(posedge clk_i);
    end
    q = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // idle cycle: no double assignment in one step
    @(posedge clk_i);
  endtask
endmodule

// ===== test/tb_top.sv
// self-checking bench for the charger control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cscf_pkg::*;
  localparam int unsigned TK = 4;  // short tick keeps timer runs brief
  logic REF_CLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic VBUS_POR_I = 1'b0, VBUS_UVLO_I = 1'b0, VBUS_OVP_I = 1'b0;
  logic BAT_OVP_I = 1'b0, BAT_SHORT_I = 1'b0, BAT_RECHARGE_I = 1'b0;
  logic TERM_CURRENT_I = 1'b0, SLEEP_I = 1'b0, TJ_OVER_I = 1'b0;
  logic TJ_COOL_I = 1'b1, HS_OVERCURRENT_I = 1'b0, PWM_CYCLE_I = 1'b0;
  logic VSP_REACHED_I = 1'b0, OTG_PIN_I = 1'b0;
  logic PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O;
  logic [7:0] PADDR_I;
  logic [31:0] PWDATA_I, PRDATA_O, q;
  logic CHARGE_MODE_O, BOOST_MODE_O, CHARGE_EN_O, CONVERTER_EN_O;
  logic HS_GATE_EN_O, REV_SWITCH_EN_O, SHORT_CURRENT_O, FREQ_REDUCE_O;
  logic VSP_SEL_O;
  logic [1:0] INPUT_LIMIT_O;
  logic [2:0] CHARGE_CURRENT_O;
  logic [5:0] VREG_O;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  cscf_top #(.TICK_CYCLES(TK)) u_dut (.*);
  cscf_host u_host (.clk_i(REF_CLK_I), .psel_o(PSEL_I),
    .penable_o(PENABLE_I), .pwrite_o(PWRITE_I), .paddr_o(PADDR_I),
    .pwdata_o(PWDATA_I), .prdata_i(PRDATA_O), .pready_i(PREADY_O),
    .pslverr_i(PSLVERR_O));
  // ****************************************************************
  // clock, hang limit and shared tasks
  // ****************************************************************
  initial begin
    forever #25 REF_CLK_I = ~REF_CLK_I;
  end
  // safety run is about ten thousand cycles
  always @(posedge REF_CLK_I) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  task finish_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x, input string m);
    checks++;
    if (s !== x) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s: %h vs %h", $time, m, s, x);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge REF_CLK_I);
  endtask
  task rd(input logic [7:0] a);
    logic e;
    u_host.xfer(1'b0, a, 32'h0000_0000, q, e);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    u_host.xfer(1'b1, a, {24'h00_0000, d}, r, e);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_regs();
    logic e;
    rd(8'h04);
    chk(q, 32'h0000_0008, "ctrl1 reset");
    rd(8'h18);
    chk(q, 32'h0000_0000, "watchdog off");
    rd(8'h00);
    chk(q, 32'h0000_0010, "charging code");
    u_host.xfer(1'b1, 8'h1C, 32'h0000_00FF, q, e);
    chk(e, 1'b1, "unmapped error");
    rd(8'h1C);
    chk(q, 32'h0000_0000, "unmapped read");
    $display("test regs done");
  endtask
  task t_clamp();
    wr(8'h10, 8'h35);
    rd(8'h10);
    chk(q, 32'h0000_0033, "clamped");
    chk(CHARGE_CURRENT_O, 3'h3, "clamped out");
    wr(8'h10, 8'h72);
    rd(8'h10);
    chk(q, 32'h0000_0072, "below ceiling");
    $display("test clamp done");
  endtask
  // pin allow, polarity, pin, request, boost
  task t_boost();
    logic [4:0] tb_row [6];
    tb_row = '{5'h1D, 5'h11, 5'h03, 5'h14, 5'h18, 5'h0C};
    for (int i = 0; i < 6; i++) begin
      wr(8'h08, {6'h00, tb_row[i][4], tb_row[i][3]});
      OTG_PIN_I <= tb_row[i][2];
      wr(8'h04, {7'h64, tb_row[i][1]});
      cyc(4);
      chk(BOOST_MODE_O, tb_row[i][0], "boost");
      chk(CHARGE_MODE_O, !tb_row[i][0], "charge");
      chk(INPUT_LIMIT_O, tb_row[i][0] ? 2'h1 : 2'h3, "limit");
    end
    wr(8'h04, 8'h0A);
    cyc(4);
    chk({CHARGE_MODE_O, BOOST_MODE_O, CHARGE_EN_O}, 3'h0, "hiz");
    wr(8'h04, 8'h08);
    cyc(6);
    $display("test boost done");
  endtask
  task t_faults();
    logic [2:0] fc [3];
    fc = '{FLT_VBUS_OVP, FLT_UVLO, FLT_BAT_OVP};
    rd(8'h00);
    for (int i = 0; i < 3; i++) begin
      {BAT_OVP_I, VBUS_UVLO_I, VBUS_OVP_I} <= 3'h1 << i;
      cyc(6);
      chk(CHARGE_EN_O, 1'b0, "stopped");
      rd(8'h00);
      chk(q, {26'h000_0000, STAT_FAULT, 1'b0, fc[i]}, "code");
      {BAT_OVP_I, VBUS_UVLO_I, VBUS_OVP_I} <= 3'h0;
      cyc(6);
      rd(8'h00);
      rd(8'h00);
      chk(q, 32'h0000_0010, "cleared");
      chk(CHARGE_EN_O, 1'b1, "resumed");
    end
    // unread code survives a later fault
    VBUS_OVP_I <= 1'b1;
    cyc(6);
    VBUS_OVP_I <= 1'b0;
    VBUS_UVLO_I <= 1'b1;
    cyc(6);
    rd(8'h00);
    chk(q[2:0], FLT_VBUS_OVP, "locked");
    VBUS_UVLO_I <= 1'b0;
    cyc(6);
    rd(8'h00);
    rd(8'h00);
    $display("test faults done");
  endtask
  task t_thermal();
    TJ_COOL_I <= 1'b0;
    TJ_OVER_I <= 1'b1;
    cyc(6);
    chk(CONVERTER_EN_O, 1'b0, "hot stop");
    TJ_OVER_I <= 1'b0;
    TJ_COOL_I <= 1'b1;
    cyc(6);
    chk(CONVERTER_EN_O, 1'b1, "cool resume");
    $display("test thermal done");
  endtask
  task t_misc();
    SLEEP_I <= 1'b1;
    cyc(6);
    chk(REV_SWITCH_EN_O, 1'b0, "sleep");
    SLEEP_I <= 1'b0;
    BAT_SHORT_I <= 1'b1;
    cyc(6);
    chk(SHORT_CURRENT_O, 1'b1, "short");
    BAT_SHORT_I <= 1'b0;
    HS_OVERCURRENT_I <= 1'b1;
    cyc(6);
    chk(HS_GATE_EN_O, 1'b0, "peak");
    HS_OVERCURRENT_I <= 1'b0;
    PWM_CYCLE_I <= 1'b1;
    cyc(6);
    chk(HS_GATE_EN_O, 1'b1, "next cycle");
    PWM_CYCLE_I <= 1'b0;
    wr(8'h14, 8'h10);
    VSP_REACHED_I <= 1'b1;
    cyc(6);
    chk({VSP_SEL_O, FREQ_REDUCE_O}, 2'h3, "special");
    VSP_REACHED_I <= 1'b0;
    wr(8'h04, 8'h00);
    TERM_CURRENT_I <= 1'b1;
    cyc(6);
    chk(CHARGE_EN_O, 1'b1, "no term");
    wr(8'h04, 8'h08);
    cyc(6);
    chk(CHARGE_EN_O, 1'b0, "term");
    TERM_CURRENT_I <= 1'b0;
    BAT_RECHARGE_I <= 1'b1;
    cyc(6);
    chk(CHARGE_EN_O, 1'b1, "recharge");
    BAT_RECHARGE_I <= 1'b0;
    $display("test misc done");
  endtask
  task t_wd();
    wr(8'h04, 8'hC8);
    wr(8'h18, 8'h80);
    repeat (3) begin
      cyc(100);
      wr(8'h08, 8'h04);
    end
    wr(8'h00, 8'h80);
    cyc(100);
    rd(8'h04);
    chk(q, 32'h0000_00C8, "kept alive");
    cyc(33 * TK + 20);
    rd(8'h04);
    chk(q, 32'h0000_0008, "defaults");
    chk({VREG_O, CHARGE_CURRENT_O}, 9'h000, "params");
    chk(CHARGE_EN_O, 1'b1, "resumes");
    wr(8'h18, 8'h00);
    $display("test watchdog done");
  endtask
  task t_safety();
    VBUS_POR_I <= 1'b0;
    cyc(6);
    VBUS_POR_I <= 1'b1;
    cyc(6);
    cyc(SAFETY_TICKS * TK - 60);
    chk(CHARGE_EN_O, 1'b1, "timer running");
    cyc(100);
    chk(CHARGE_EN_O, 1'b0, "timer expired");
    rd(8'h04);
    chk(q[2], 1'b1, "disable set");
    rd(8'h00);
    chk(q, 32'h0000_0006, "timer fault");
    wr(8'h04, 8'h08);
    cyc(6);
    chk(CHARGE_EN_O, 1'b1, "restart");
    $display("test safety done");
  endtask
  initial begin
    cyc(12);
    RST_I <= 1'b0;
    VBUS_POR_I <= 1'b1;  // power-good edge restarts the safety timer
    cyc(8);
    t_regs();
    t_clamp();
    t_boost();
    t_faults();
    t_thermal();
    t_misc();
    t_wd();
    t_safety();
    finish_test();
  end
endmodule
